// ### mpl_regs.vh
// Purpose: register indices, field positions and reset values
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef MPL_REGS_VH
`define MPL_REGS_VH

// register indices
`define MPL_IDX_GEN_FLAG  16'h8029
`define MPL_IDX_LOOP      16'h8055
`define MPL_IDX_SOP       16'h805a
`define MPL_IDX_CNT_HI    16'h8027
`define MPL_IDX_CNT_LO    16'h8028
`define MPL_IDX_FG_START  16'h8030

// reset values
`define MPL_RST_GEN_FLAG  16'h0000
`define MPL_RST_LOOP      4'ha
`define MPL_RST_SOP       6'h1b
`define MPL_RST_CNT_HI    16'h0000
`define MPL_RST_CNT_LO    16'h0100

// loopback config fields
`define MPL_LB_LOCAL_EN   0
`define MPL_LB_LOCAL_SUP  1
`define MPL_LB_REM_EN     2
`define MPL_LB_REM_SUP    3
`define MPL_LB_W          4

// start indication control fields
`define MPL_SOP_RX_EN     0
`define MPL_SOP_RX_SFD    1
`define MPL_SOP_RX_LEN    2
`define MPL_SOP_TX_EN     3
`define MPL_SOP_TX_SFD    4
`define MPL_SOP_TX_LEN    5
`define MPL_SOP_W         6

// frame generator start register fields
`define MPL_FG_GO         0
`define MPL_FG_BUSY       1

// stream constants
`define MPL_SFD           8'hd5
`define MPL_PRE_LAST      4'h7
`define MPL_FIFO_DEPTH    32

// bus answers and register selects
`define MPL_RESP_OKAY     2'b00
`define MPL_RESP_SLVERR   2'b10
`define MPL_SEL_NONE      3'h0
`define MPL_SEL_DONE      3'h1
`define MPL_SEL_LOOP      3'h2
`define MPL_SEL_SOP       3'h3
`define MPL_SEL_CNT_HI    3'h4
`define MPL_SEL_CNT_LO    3'h5
`define MPL_SEL_FG        3'h6

`endif

// ### mpl_fifo.v
// Purpose: byte stream fifo with valid and ready on both sides
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes:   ready and valid come from flops
`timescale 1ns/1ps
`default_nettype none

module mpl_fifo #(
  parameter W     = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         ce,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output reg          in_ready,
  output wire [W-1:0] out_data,
  output reg          out_valid,
  input  wire         out_ready
);

  localparam [AW:0] FULL = DEPTH[AW:0];

  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  reg  [AW:0]   cnt_q;
  reg  [AW:0]   cnt_d;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign out_data = mem[rd_q];

  // occupancy after this cycle
  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop & ~push)
      cnt_d = cnt_q - 1'b1;
  end

  // pointers, storage, registered flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q      <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != FULL);
      out_valid <= (cnt_d != {(AW+1){1'b0}});
    end
  end

endmodule
`default_nettype wire

// ### mpl_sop_det.v
// Purpose: start-of-packet indication for one byte stream
// Assumes: one byte per byte_vld, byte_last marks the frame's last byte
// Notes:   indication drops at the edge that takes the last byte
`timescale 1ns/1ps
`default_nettype none
`include "mpl_regs.vh"

module mpl_sop_det (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  input  wire       det_en,
  input  wire       sfd_en,
  input  wire       len_chk,
  input  wire       byte_vld,
  input  wire [7:0] byte_data,
  input  wire       byte_last,
  output reg        sop
);

  reg [3:0] cnt_q;
  reg       quit_q;

  // byte counter, give-up flag and held indication
  always @(posedge aclk) begin
    if (!aresetn) begin
      sop    <= 1'b0;
      cnt_q  <= 4'h0;
      quit_q <= 1'b0;
    end else if (ce && byte_vld) begin
      if (byte_last) begin
        sop    <= 1'b0;
        cnt_q  <= 4'h0;
        quit_q <= 1'b0;
      end else begin
        if (cnt_q != 4'hf)
          cnt_q <= cnt_q + 4'h1;
        if (det_en && !sop && !quit_q) begin
          if (!sfd_en)
            sop <= 1'b1;
          else if (byte_data == `MPL_SFD)
            sop <= 1'b1;
          else if (cnt_q == `MPL_PRE_LAST) begin
            sop    <= len_chk;
            quit_q <= ~len_chk;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### mpl_ctrl.v
// Purpose: loopbacks, start indications and generator done flag
// Assumes: byte-wide streams, registers over axi4-lite
// Notes:   byte address of a register is four times its index
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mpl_regs.vh"

// Contract
// [RULE_01] set done flag when generator has sent the requested frame count
// [RULE_02] done flag stays high until read; the read returns 1 and clears
// [RULE_03] loopback bit 0 routes mac transmit data into mac receive
// [RULE_04] local loop with bit 1 set withholds transmit data from phy
// [RULE_05] loopback bit 2 routes phy receive data into phy transmit
// [RULE_06] remote loop with bit 3 set withholds receive data from mac
// [RULE_07] receive start indication only while its enable bit 0 is set
// [RULE_08] enable and on-delimiter bits set: indicate when sfd arrives
// [RULE_09] without on-delimiter: indicate as soon as data valid rises
// [RULE_10] receive indication held until the current frame ends
// [RULE_11] length check set: indicate after eight bytes without sfd
// [RULE_12] length check clear: no indication if no sfd in eight bytes
// [RULE_13] transmit start indication only while enable bit 3 is set
// [RULE_14] transmit on-delimiter bit 4 indicates at the sfd
// [RULE_15] transmit length check bit 5 applies the preamble check
// [RULE_16] frame count is 32 bits held as two 16-bit halves
// [RULE_17] suppress bits do nothing while their loopback is disabled
module mpl_ctrl #(
  parameter ADDR_W = 18,
  parameter FIFO_W = 9,
  parameter FIFO_D = `MPL_FIFO_DEPTH,
  parameter FIFO_A = 5
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  input  wire [7:0]        mac_tx_data,
  input  wire              mac_tx_last,
  input  wire              mac_tx_valid,
  output wire              mac_tx_ready,
  output reg  [7:0]        mac_rx_data,
  output reg               mac_rx_last,
  output reg               mac_rx_valid,
  output wire              mac_rx_sop,
  input  wire [7:0]        phy_rx_data,
  input  wire              phy_rx_dv,
  output reg  [7:0]        phy_tx_data,
  output reg               phy_tx_last,
  output reg               phy_tx_valid,
  input  wire              phy_tx_ready,
  output wire              phy_tx_sop,
  input  wire              fg_frame_sent,
  output reg               fg_run
);

  // register contents
  reg [`MPL_LB_W-1:0]  loop_q;
  reg [`MPL_SOP_W-1:0] sop_cfg_q;
  reg [15:0]           cnt_hi_q;
  reg [15:0]           cnt_lo_q;
  reg                  done_q;
  reg [31:0]           sent_q;

  // bus state
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0]       w_data_q;
  reg [3:0]        w_strb_q;

  // phy receive stage
  reg [7:0] rxd_q;
  reg       rxv_q;

  // map an address onto a register select
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    reg   [15:0]       idx;
    begin
      idx     = a[17:2];
      reg_sel = `MPL_SEL_NONE;
      if (a[1:0] == 2'b00) begin
        case (idx)
          `MPL_IDX_GEN_FLAG: reg_sel = `MPL_SEL_DONE;
          `MPL_IDX_LOOP:     reg_sel = `MPL_SEL_LOOP;
          `MPL_IDX_SOP:      reg_sel = `MPL_SEL_SOP;
          `MPL_IDX_CNT_HI:   reg_sel = `MPL_SEL_CNT_HI;
          `MPL_IDX_CNT_LO:   reg_sel = `MPL_SEL_CNT_LO;
          `MPL_IDX_FG_START: reg_sel = `MPL_SEL_FG;
          default:           reg_sel = `MPL_SEL_NONE;
        endcase
      end
    end
  endfunction

  // merge a 16-bit register with a strobed write
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // write and read decode
  wire [2:0] wsel   = reg_sel(aw_addr_q);
  wire       do_wr  = ~awready & ~wready & ~bvalid;
  wire [2:0] rsel   = reg_sel(araddr);
  wire       do_rd  = arready & arvalid;
  wire       fg_go  = do_wr && (wsel == `MPL_SEL_FG) && w_strb_q[0]
                      && w_data_q[`MPL_FG_GO];
  wire [31:0] target = {cnt_hi_q, cnt_lo_q}; // see [RULE_16]
  wire       last_frame = fg_run && fg_frame_sent
                          && (sent_q + 32'h1 == target);
  wire       done_set = last_frame || (fg_go && target == 32'h0);
  wire [15:0] loop_wr = merge16({12'h000, loop_q}, w_data_q, w_strb_q);
  wire [15:0] sop_wr  = merge16({10'h000, sop_cfg_q}, w_data_q, w_strb_q);

  // effective loopback modes; suppress only counts with its loop
  wire lb_local = loop_q[`MPL_LB_LOCAL_EN];   // see [RULE_03]
  wire lb_rem   = loop_q[`MPL_LB_REM_EN];     // see [RULE_05]
  wire sup_tx   = lb_local & loop_q[`MPL_LB_LOCAL_SUP]; // see [RULE_17]
  wire sup_rx   = lb_rem & loop_q[`MPL_LB_REM_SUP];     // see [RULE_17]

  // fifo between mac transmit and phy transmit
  wire [FIFO_W-1:0] f_out;
  wire              f_valid;
  wire              f_ready;
  wire              tx_slot = ~phy_tx_valid | phy_tx_ready;

  mpl_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_A)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_data   ({mac_tx_last, mac_tx_data}),
    .in_valid  (mac_tx_valid),
    .in_ready  (mac_tx_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // remote loop owns the phy transmit, so mac transmit stalls there
  assign f_ready = ~lb_rem & (sup_tx | tx_slot);
  wire f_take = f_valid & f_ready;

  // phy receive stream, last byte known when dv falls
  wire rx_last = rxv_q & ~phy_rx_dv;

  // stream toward phy transmit
  reg       tx_v;
  reg [7:0] tx_d;
  reg       tx_l;
  always @* begin
    tx_v = 1'b0;
    tx_d = f_out[7:0];
    tx_l = f_out[8];
    if (lb_rem) begin
      tx_v = rxv_q & tx_slot;                 // see [RULE_05]
      tx_d = rxd_q;
      tx_l = rx_last;
    end else if (!sup_tx) begin
      tx_v = f_take;                          // see [RULE_04]
    end
  end

  // stream toward mac receive
  reg       rx_v;
  reg [7:0] rx_d;
  reg       rx_l;
  always @* begin
    rx_v = 1'b0;
    rx_d = rxd_q;
    rx_l = rx_last;
    if (lb_local) begin
      rx_v = f_take;                          // see [RULE_03]
      rx_d = f_out[7:0];
      rx_l = f_out[8];
    end else if (!sup_rx) begin
      rx_v = rxv_q;                           // see [RULE_06]
    end
  end

  // receive start indication
  mpl_sop_det u_rx_sop (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .det_en    (sop_cfg_q[`MPL_SOP_RX_EN]),   // see [RULE_07]
    .sfd_en    (sop_cfg_q[`MPL_SOP_RX_SFD]),  // see [RULE_08] [RULE_09]
    .len_chk   (sop_cfg_q[`MPL_SOP_RX_LEN]),  // see [RULE_11] [RULE_12]
    .byte_vld  (rx_v),
    .byte_data (rx_d),
    .byte_last (rx_l),                        // see [RULE_10]
    .sop       (mac_rx_sop)
  );

  // transmit start indication
  mpl_sop_det u_tx_sop (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .det_en    (sop_cfg_q[`MPL_SOP_TX_EN]),   // see [RULE_13]
    .sfd_en    (sop_cfg_q[`MPL_SOP_TX_SFD]),  // see [RULE_14]
    .len_chk   (sop_cfg_q[`MPL_SOP_TX_LEN]),  // see [RULE_15]
    .byte_vld  (tx_v),
    .byte_data (tx_d),
    .byte_last (tx_l),
    .sop       (phy_tx_sop)
  );

  // output stages of both streams
  always @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q        <= 8'h00;
      rxv_q        <= 1'b0;
      mac_rx_data  <= 8'h00;
      mac_rx_last  <= 1'b0;
      mac_rx_valid <= 1'b0;
      phy_tx_data  <= 8'h00;
      phy_tx_last  <= 1'b0;
      phy_tx_valid <= 1'b0;
    end else if (ce) begin
      rxd_q        <= phy_rx_data;
      rxv_q        <= phy_rx_dv;
      mac_rx_valid <= rx_v;
      mac_rx_data  <= rx_d;
      mac_rx_last  <= rx_v & rx_l;
      if (tx_slot) begin
        phy_tx_valid <= tx_v;
        phy_tx_data  <= tx_d;
        phy_tx_last  <= tx_v & tx_l;
      end
    end
  end

  // write address and data channels, then response
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `MPL_RESP_OKAY;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (awready && awvalid) begin
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end
      if (wready && wvalid) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready   <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= (wsel == `MPL_SEL_NONE) ? `MPL_RESP_SLVERR
                                          : `MPL_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      loop_q    <= `MPL_RST_LOOP;
      sop_cfg_q <= `MPL_RST_SOP;
      cnt_hi_q  <= `MPL_RST_CNT_HI;
      cnt_lo_q  <= `MPL_RST_CNT_LO;
    end else if (ce && do_wr) begin
      case (wsel)
        `MPL_SEL_LOOP:
          loop_q <= loop_wr[`MPL_LB_W-1:0];
        `MPL_SEL_SOP:
          sop_cfg_q <= sop_wr[`MPL_SOP_W-1:0];
        `MPL_SEL_CNT_HI:
          cnt_hi_q <= merge16(cnt_hi_q, w_data_q, w_strb_q);
        `MPL_SEL_CNT_LO:
          cnt_lo_q <= merge16(cnt_lo_q, w_data_q, w_strb_q);
        default:
          cnt_lo_q <= cnt_lo_q;
      endcase
    end
  end

  // frame generator run control and done flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      fg_run <= 1'b0;
      sent_q <= 32'h0;
      done_q <= 1'b0;
    end else if (ce) begin
      if (fg_go) begin
        sent_q <= 32'h0;
        fg_run <= (target != 32'h0);
      end else if (fg_run && fg_frame_sent) begin
        sent_q <= sent_q + 32'h1;
        if (last_frame)
          fg_run <= 1'b0;
      end
      // a set in the same cycle as the clearing read wins
      if (done_set)
        done_q <= 1'b1;                       // see [RULE_01]
      else if (do_rd && rsel == `MPL_SEL_DONE)
        done_q <= 1'b0;                       // see [RULE_02]
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `MPL_RESP_OKAY;
    end else if (ce) begin
      if (do_rd) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `MPL_RESP_OKAY;
        case (rsel)
          `MPL_SEL_DONE:   rdata <= {31'h0, done_q}; // see [RULE_02]
          `MPL_SEL_LOOP:   rdata <= {28'h0, loop_q};
          `MPL_SEL_SOP:    rdata <= {26'h0, sop_cfg_q};
          `MPL_SEL_CNT_HI: rdata <= {16'h0, cnt_hi_q};
          `MPL_SEL_CNT_LO: rdata <= {16'h0, cnt_lo_q};
          `MPL_SEL_FG:     rdata <= {30'h0, fg_run, 1'b0};
          default: begin
            rdata <= 32'h0;
            rresp <= `MPL_RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### mpl_ctrl_props.sv
// Purpose: port checker for the loopback and start indication block
// Assumes: one clock, synchronous active low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none

module mpl_ctrl_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       mac_rx_valid,
  input wire logic       mac_rx_last,
  input wire logic       mac_rx_sop,
  input wire logic       phy_tx_valid,
  input wire logic       phy_tx_ready,
  input wire logic [7:0] phy_tx_data,
  input wire logic       phy_tx_sop
);
  // single domain, checks sleep during reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // receive start indication
  property p_rx_rise;
    $rose(mac_rx_sop) |-> mac_rx_valid;
  endproperty
  a_rx_rise: assert property (p_rx_rise)
    else $error("rx start rose without a byte");
  property p_rx_hold;
    mac_rx_sop |=> mac_rx_sop || (mac_rx_valid && mac_rx_last);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx start dropped inside a frame");
  property p_rx_last;
    mac_rx_valid && mac_rx_last |-> !mac_rx_sop;
  endproperty
  a_rx_last: assert property (p_rx_last)
    else $error("rx start still high on last byte");

  // transmit stream and its indication
  property p_tx_rise;
    $rose(phy_tx_sop) |-> phy_tx_valid;
  endproperty
  a_tx_rise: assert property (p_tx_rise)
    else $error("tx start rose without a byte");
  property p_tx_hold;
    phy_tx_valid && !phy_tx_ready |=>
      phy_tx_valid && $stable(phy_tx_data) && $stable(phy_tx_sop);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte changed while stalled");

  // register bus answers
  property p_b_lat;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer late");
  property p_b_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_busy: assert property (p_b_busy)
    else $error("write taken while answer pending");
  property p_r_lat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer not one cycle after");

  // main scenarios reached
  c_rx: cover property ($rose(mac_rx_sop));
  c_tx: cover property ($rose(phy_tx_sop));
  c_stall: cover property (phy_tx_valid && !phy_tx_ready);
endmodule
`default_nettype wire

// ### mpl_phy_model.sv
// Purpose: phy side model, receive frames and transmit acceptance
// Assumes: one byte per cycle while receive valid is high
// Notes:   released data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none

module mpl_phy_model (
  input  wire logic       aclk,
  input  wire logic       slow,
  output var  logic [7:0] phy_rx_data,
  output var  logic       phy_rx_dv,
  output var  logic       phy_tx_ready
);
  // idle lines at time zero
  initial begin
    phy_rx_data = 8'h00;
    phy_rx_dv = 1'h0;
    phy_tx_ready = 1'h1;
  end

  // random stalls only while slow is asked for
  always @(posedge aclk) begin
    phy_tx_ready <= slow ? 1'($urandom) : 1'h1;
  end

  // one frame, then a gap with the data line no longer valid
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge aclk);
      phy_rx_dv <= 1'h1;
      phy_rx_data <= b[i];
    end
    @(posedge aclk);
    phy_rx_dv <= 1'h0;
    phy_rx_data <= ~b[b.size() - 1];
    repeat (4) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for loopbacks and start indications
// Assumes: phy modelled apart, registers reached over axi4-lite
// Notes:   expected bytes built in queues from the control bits
`timescale 1ns/1ps
`default_nettype none
`include "mpl_regs.vh"

module testbench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ce = 1'h1;
  logic [17:0] awaddr = 18'h0;
  logic [17:0] araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        arvalid = 1'h0;
  logic        bready = 1'h1;
  logic        rready = 1'h1;
  logic [7:0]  mac_tx_data = 8'h0;
  logic        mac_tx_last = 1'h0;
  logic        mac_tx_valid = 1'h0;
  logic        fg_frame_sent = 1'h0;
  logic        slow = 1'h0;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  mac_rx_data, phy_tx_data, phy_rx_data;
  wire         awready, wready, bvalid, arready, rvalid, mac_tx_ready;
  wire         mac_rx_last, mac_rx_valid, mac_rx_sop, phy_rx_dv;
  wire         phy_tx_last, phy_tx_valid, phy_tx_ready, phy_tx_sop, fg_run;
  int          err_total = 0;
  int          checked = 0;
  int          k;
  int          n;
  logic [7:0]  fr[$];
  logic [9:0]  qr[$];
  logic [9:0]  qt[$];
  logic [5:0]  ctab[5] = '{6'h1b, 6'h1b, 6'h3f, 6'h02, 6'h29};
  int          stab[5] = '{5, 9, 10, 3, 4};
  logic [3:0]  lbt[6] = '{4'h3, 4'h1, 4'h2, 4'hc, 4'h4, 4'h8};

  // clock and parts
  always #20 aclk = ~aclk;
  mpl_ctrl mpl_ctrl_i (.*);
  mpl_phy_model mpl_phy_model_i (.*);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("counts: compares=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // bus cycles, payloads held until taken
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    awaddr <= {i, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk(bresp, `MPL_RESP_OKAY);
  endtask

  task automatic rc(input logic [15:0] i, input logic [31:0] e,
                    input logic [1:0] r);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    chk(rdata, e);
    chk(rresp, r);
  endtask

  // frame of preamble, delimiter at s, random payload
  task automatic mk(input int s);
    int i;
    fr = {};
    for (i = 0; i < 12; i++)
      fr.push_back(i < s ? 8'h55 : i == s ? `MPL_SFD : 8'($urandom));
  endtask

  // expected bytes with their start indication
  task automatic push(input bit tx, input logic [2:0] c,
                      input logic [7:0] b[$]);
    int st;
    logic [9:0] e;
    st = 99;
    if (c[0] && !c[1]) st = 0;
    if (c[0] && c[1]) begin
      for (int i = 7; i >= 0; i--)
        if (b[i] == `MPL_SFD) st = i;
      if (st == 99 && c[2]) st = 7;
    end
    // last flag, start indication, byte
    foreach (b[i]) begin
      e = {i == b.size() - 1, i >= st && i < b.size() - 1,
           b[i]};
      if (tx) qt.push_back(e);
      else qr.push_back(e);
    end
  endtask

  function automatic logic [9:0] pop(input bit t);
    if (t) return qt.size() ? qt.pop_front() : 'x;
    return qr.size() ? qr.pop_front() : 'x;
  endfunction

  task automatic msend(input logic [7:0] b[$]);
    foreach (b[i]) begin
      mac_tx_data <= b[i];
      mac_tx_last <= (i == b.size() - 1);
      mac_tx_valid <= 1'h1;
      do @(posedge aclk); while (!mac_tx_ready);
    end
    mac_tx_valid <= 1'h0;
    mac_tx_last <= 1'h0;
    mac_tx_data <= ~b[b.size() - 1];
  endtask

  task automatic drain;
    while (qr.size() + qt.size() > 0) @(posedge aclk);
    repeat (8) @(posedge aclk);
    chk(qr.size() + qt.size(), 0);
  endtask

  // compare every output byte with the expected queues
  always @(posedge aclk) begin
    if (aresetn && mac_rx_valid)
      chk({mac_rx_last, mac_rx_sop, mac_rx_data}, pop(0));
    if (aresetn && phy_tx_valid && phy_tx_ready)
      chk({phy_tx_last, phy_tx_sop, phy_tx_data}, pop(1));
  end

  // main sequence
  initial begin
    void'($urandom(23681));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(`MPL_IDX_LOOP, 32'h000a, 2'h0);
    rc(`MPL_IDX_SOP, 32'h001b, 2'h0);
    rc(`MPL_IDX_GEN_FLAG, 32'h0, 2'h0);
    rc(`MPL_IDX_CNT_LO, 32'h0100, 2'h0);
    rc(16'h0100, 32'h0, `MPL_RESP_SLVERR);
    $display("test registers done");
    for (k = 0; k < 5; k++) begin
      wr(`MPL_IDX_SOP, {10'h0, ctab[k]});
      mk(stab[k]);
      push(0, ctab[k][2:0], fr);
      push(1, ctab[k][5:3], fr);
      fork
        mpl_phy_model_i.send(fr);
        msend(fr);
      join
      drain;
    end
    $display("test start indications done");
    wr(`MPL_IDX_SOP, 16'h001b);
    for (k = 0; k < 6; k++) begin
      wr(`MPL_IDX_LOOP, {12'h0, lbt[k]});
      mk(5);
      if (k < 3) begin
        if (lbt[k][0]) push(0, 3'h3, fr);
        if (!(lbt[k][0] && lbt[k][1])) push(1, 3'h3, fr);
        msend(fr);
      end else begin
        if (lbt[k][2]) push(1, 3'h3, fr);
        if (!(lbt[k][2] && lbt[k][3])) push(0, 3'h3, fr);
        mpl_phy_model_i.send(fr);
      end
      drain;
    end
    $display("test loopbacks done");
    wr(`MPL_IDX_LOOP, 16'h000c);
    n = 0;
    mac_tx_data <= 8'h00;
    mac_tx_valid <= 1'h1;
    repeat (80) begin
      @(posedge aclk);
      if (mac_tx_ready) begin
        n++;
        mac_tx_data <= 8'(n);
        mac_tx_last <= (n == `MPL_FIFO_DEPTH - 1);
      end
    end
    mac_tx_valid <= 1'h0;
    chk(n, `MPL_FIFO_DEPTH);
    fr = {};
    for (k = 0; k < n; k++) fr.push_back(8'(k));
    push(1, 3'h3, fr);
    slow <= 1'h1;
    wr(`MPL_IDX_LOOP, 16'h0000);
    drain;
    slow <= 1'h0;
    $display("test buffer fill and drain done");
    wr(`MPL_IDX_CNT_LO, 16'h0002);
    wr(`MPL_IDX_FG_START, 16'h0001);
    chk(fg_run, 1'h1);
    // a frame reported while frozen must not count
    ce <= 1'h0;
    fg_frame_sent <= 1'h1;
    @(posedge aclk);
    ce <= 1'h1;
    fg_frame_sent <= 1'h0;
    for (k = 0; k < 2; k++) begin
      fg_frame_sent <= 1'h1;
      @(posedge aclk);
      fg_frame_sent <= 1'h0;
      repeat (4) @(posedge aclk);
      rc(`MPL_IDX_GEN_FLAG, 32'(k), 2'h0);
    end
    chk(fg_run, 1'h0);
    rc(`MPL_IDX_GEN_FLAG, 32'h0, 2'h0);
    $display("test generator done flag done");
    complete_run;
  end

  // watchdog against a hang
  initial begin
    #(40 * 30000);
    err_total++;
    complete_run;
  end
endmodule

bind mpl_ctrl mpl_ctrl_chk mpl_ctrl_chk_i (.*);
`default_nettype wire
